// ---- shared/gpbm_defines.vh ----
// register map, field positions and fixed values of the packet buffer manager
`ifndef GPBM_DEFINES_VH
`define GPBM_DEFINES_VH

// ==========================================================
// register byte offsets
`define GPBM_REG_CTRL      8'h00
`define GPBM_REG_TXCFG     8'h04
`define GPBM_REG_RXCFG     8'h08
`define GPBM_REG_ETT       8'h0C
`define GPBM_REG_MAC_LO    8'h10
`define GPBM_REG_MAC_HI    8'h14
`define GPBM_REG_HASH_LO   8'h18
`define GPBM_REG_HASH_HI   8'h1C
`define GPBM_REG_TYPE      8'h20
`define GPBM_REG_PATTERN   8'h24
`define GPBM_REG_PATMASK   8'h28
`define GPBM_REG_DESC_ADDR 8'h2C
`define GPBM_REG_DESC_QUE  8'h30
`define GPBM_REG_STATUS    8'h34
`define GPBM_REG_LEVEL     8'h38

// ==========================================================
// control register bits
`define GPBM_CTRL_TX_EN    0
`define GPBM_CTRL_RX_EN    1
`define GPBM_CTRL_ACC_BC   2
`define GPBM_CTRL_ACC_MC   3
`define GPBM_CTRL_ACC_UC   4
`define GPBM_CTRL_TYPE_EN  5
`define GPBM_CTRL_ACC_ALL  6
`define GPBM_CTRL_WAKE_EN  7
`define GPBM_CTRL_RESET    8'h00

// ==========================================================
// config fields: burst code [2:0], threshold from bit 4
`define GPBM_BURST_LSB     0
`define GPBM_THR_LSB       4
`define GPBM_TX_THR_RESET  12'h100
`define GPBM_RX_THR_RESET  14'h0040
`define GPBM_ETT_RESET     12'h080
`define GPBM_BURST_RESET   3'h2
`define GPBM_BURST_UNLIM   3'h7
`define GPBM_DESC_HI_BIT   31

// ==========================================================
// status bits, bits 2..5 are write-one-to-clear
`define GPBM_ST_HI_BUSY    0
`define GPBM_ST_LO_BUSY    1
`define GPBM_ST_PAUSE      2
`define GPBM_ST_WAKE       3
`define GPBM_ST_PATTERN    4
`define GPBM_ST_DROP       5

// ==========================================================
// fifo sizes in 32-bit words: 8KB transmit, 32KB receive
`define GPBM_TX_DEPTH      12'h800
`define GPBM_RX_DEPTH      14'h2000

// ==========================================================
// pause frame destination and ethertype
`define GPBM_PAUSE_DST_HI  32'h0180C200
`define GPBM_PAUSE_DST_LO  16'h0001
`define GPBM_PAUSE_TYPE    16'h8808

`endif

// ---- hw/gpbm_skid.v ----
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module gpbm_skid #(
   parameter W = 33
) (
   // clock and reset
   input  wire         hclk,
   input  wire         hresetn,
   // filling side
   input  wire [W-1:0] in_data,
   input  wire         in_valid,
   output wire         in_ready,
   // draining side
   output reg  [W-1:0] out_data,
   output reg          out_valid,
   input  wire         out_ready
);
   reg [W-1:0] spare;
   reg         spare_vld;
   wire        push = in_valid & ~spare_vld;
   wire        pop  = out_valid & out_ready;

   // ready only from a flop, so a stall never ripples back combinationally
   assign in_ready = ~spare_vld;

   // ==========================================================
   // head and spare entries
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_data  <= {W{1'b0}};
         out_valid <= 1'b0;
         spare     <= {W{1'b0}};
         spare_vld <= 1'b0;
      end else if (pop) begin
         if (spare_vld) begin
            out_data  <= spare;
            spare_vld <= 1'b0;
         end else begin
            out_valid <= push;
            out_data  <= in_data;
         end
      end else if (push) begin
         if (!out_valid) begin
            out_data  <= in_data;
            out_valid <= 1'b1;
         end else begin
            spare     <= in_data;
            spare_vld <= 1'b1;
         end
      end
   end
endmodule // gpbm_skid

// ---- hw/gpbm_top.v ----
// packet buffer manager: transmit and receive fifos, dma pacing, receive filter
// How it works
// - transmit and receive fifos are separate and run independently
// - bus requested only when fifo space or fill reaches its threshold, or a whole frame waits in the receive fifo
// - frame start waits until transmit fifo holds early threshold words or a whole frame
// - once granted, burst continues up to max burst size of that direction
// - dma fills 8KB transmit fifo; fifo drains toward transmit mac
// - transmit fifo holds several whole frames for back to back sending
// - two descriptor slots; high priority loaded before low priority
// - descriptors hold packet info apart from data, queued by register write
// - receive mac fills 32KB receive fifo; fifo drains to dma
// - receive dma request once committed words reach receive threshold
// - receive burst stops on empty fifo, frame end, or max burst
// - filter by destination and type: broadcast, hashed multicast, unicast
// - detect wake-up, pause frames and programmed pattern matches
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "gpbm_defines.vh"
module gpbm_top (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // transmit dma from system memory
   output reg         tx_dma_req,
   output reg  [31:0] tx_dma_addr,
   output reg         tx_dma_hipri,
   input  wire [31:0] tx_dma_data,
   input  wire        tx_dma_valid,
   output reg         tx_dma_ready,
   // transmit mac
   output wire [31:0] tx_mac_data,
   output wire        tx_mac_last,
   output wire        tx_mac_valid,
   input  wire        tx_mac_ready,
   // receive mac
   input  wire [31:0] rx_mac_data,
   input  wire        rx_mac_valid,
   input  wire        rx_mac_last,
   // receive dma to system memory
   output reg         rx_dma_req,
   output wire [31:0] rx_dma_data,
   output wire        rx_dma_last,
   output wire        rx_dma_valid,
   input  wire        rx_dma_ready
);
   // ==========================================================
   // software registers
   reg  [7:0]  ctrl;
   reg  [2:0]  tx_burst_code;
   reg  [11:0] tx_fifo_threshold;
   reg  [2:0]  rx_burst_code;
   reg  [13:0] rx_fifo_threshold;
   reg  [11:0] early_tx_threshold;
   reg  [47:0] mac_addr;
   reg  [63:0] hash_tbl;
   reg  [15:0] type_match;
   reg  [31:0] pattern;
   reg  [31:0] pat_mask;
   reg  [31:0] desc_addr;
   reg         hi_vld, lo_vld;
   reg  [31:0] hi_addr, lo_addr;
   reg  [11:0] hi_len, lo_len;
   reg         st_pause, st_wake, st_pat, st_drop;
   reg         ap_wr;
   reg  [7:0]  ap_addr;
   reg  [31:0] rd_val;
   wire        ap_go = hsel & htrans[1] & hready;
   wire        wr_go = ap_wr;
   wire        q_wr  = wr_go & (ap_addr == `GPBM_REG_DESC_QUE);
   wire        st_wr = wr_go & (ap_addr == `GPBM_REG_STATUS);

   // burst code to word count; code 7 means no burst limit
   function [13:0] burst_words;
      input [2:0] code;
      begin
         if (code == `GPBM_BURST_UNLIM)
            burst_words = 14'h3FFF;
         else
            burst_words = 14'h0004 << code;
      end
   endfunction

   // ==========================================================
   // transmit state
   reg  [32:0] tx_mem [0:2047];
   reg  [11:0] tx_wr, tx_rd;
   reg  [11:0] tx_frames;
   reg         tx_act, tx_burst, tx_sending;
   reg  [11:0] tx_rem;
   reg  [13:0] tx_bl;
   wire [11:0] tx_used = tx_wr - tx_rd;
   wire [11:0] tx_free = `GPBM_TX_DEPTH - tx_used;
   wire        tx_acc  = tx_dma_valid & tx_dma_ready;
   wire        tx_skid_rdy;
   wire [32:0] tx_head = tx_mem[tx_rd[10:0]];
   wire        tx_pop  = tx_sending & (tx_used != 12'h000) & tx_skid_rdy;
   wire        tx_pop_last = tx_pop & tx_head[32];
   wire        tx_last_in  = tx_acc & (tx_rem == 12'h001);

   // ==========================================================
   // receive state
   reg  [32:0] rx_mem [0:8191];
   reg  [13:0] rx_wr, rx_cm, rx_rd;
   reg  [13:0] rx_frames;
   reg  [1:0]  rx_idx;
   reg  [31:0] rx_w0;
   reg         rx_pass, rx_busy;
   reg         st_drop_frm;
   reg  [13:0] rx_bl;
   wire [13:0] rx_used  = rx_wr - rx_rd;
   wire [13:0] rx_avail = rx_cm - rx_rd;
   wire        rx_full  = (rx_used == `GPBM_RX_DEPTH);
   wire        rx_skid_rdy;
   wire [32:0] rx_head  = rx_mem[rx_rd[12:0]];
   wire        rx_pop   = rx_busy & (rx_avail != 14'h0000) & rx_skid_rdy;
   wire        rx_pop_last = rx_pop & rx_head[32];

   // ==========================================================
   // receive filter and frame recognition on the first words
   wire [47:0] rx_dst   = {rx_w0, rx_mac_data[31:16]};
   wire [15:0] rx_type  = rx_mac_data[15:0];
   wire        is_bc    = (rx_dst == 48'hFFFFFFFFFFFF);
   wire        is_mc    = rx_dst[40] & ~is_bc;
   wire        is_uc    = (rx_dst == mac_addr);
   wire        hash_hit = hash_tbl[rx_dst[5:0]];
   wire        addr_ok  = ctrl[`GPBM_CTRL_ACC_ALL]
                        | (is_bc & ctrl[`GPBM_CTRL_ACC_BC])
                        | (is_mc & hash_hit & ctrl[`GPBM_CTRL_ACC_MC])
                        | (is_uc & ctrl[`GPBM_CTRL_ACC_UC]);
   wire        type_ok  = ~ctrl[`GPBM_CTRL_TYPE_EN] | (rx_type == type_match);
   wire        w1_now   = rx_mac_valid & (rx_idx == 2'h1);
   wire        w2_now   = rx_mac_valid & (rx_idx == 2'h2);
   wire        is_pause = w1_now & (rx_w0 == `GPBM_PAUSE_DST_HI)
                        & (rx_mac_data[31:16] == `GPBM_PAUSE_DST_LO)
                        & (rx_type == `GPBM_PAUSE_TYPE);
   wire        pat_hit  = w2_now & (((rx_mac_data ^ pattern) & pat_mask) == 32'h00000000);
   wire        pass_now = (rx_idx == 2'h1) ? (addr_ok & type_ok) : rx_pass;
   wire        rx_drop_now = rx_mac_valid & (st_drop_frm | rx_full);
   wire        rx_commit = rx_mac_valid & rx_mac_last & ~rx_drop_now & (rx_idx != 2'h0)
                         & pass_now & ctrl[`GPBM_CTRL_RX_EN];

   // ==========================================================
   // ahb-lite: zero wait states, read data registered in address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr     <= 1'b0;
         ap_addr   <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         ap_wr <= ap_go & hwrite;
         if (ap_go)
            ap_addr <= haddr[7:0];
         if (ap_go & ~hwrite)
            hrdata <= rd_val;
      end
   end

   // read mux, unmapped offsets read zero
   always @* begin
      case (haddr[7:0])
         `GPBM_REG_CTRL:      rd_val = {24'h000000, ctrl};
         `GPBM_REG_TXCFG:     rd_val = {16'h0000, tx_fifo_threshold, 1'b0, tx_burst_code};
         `GPBM_REG_RXCFG:     rd_val = {14'h0000, rx_fifo_threshold, 1'b0, rx_burst_code};
         `GPBM_REG_ETT:       rd_val = {20'h00000, early_tx_threshold};
         `GPBM_REG_MAC_LO:    rd_val = mac_addr[31:0];
         `GPBM_REG_MAC_HI:    rd_val = {16'h0000, mac_addr[47:32]};
         `GPBM_REG_HASH_LO:   rd_val = hash_tbl[31:0];
         `GPBM_REG_HASH_HI:   rd_val = hash_tbl[63:32];
         `GPBM_REG_TYPE:      rd_val = {16'h0000, type_match};
         `GPBM_REG_PATTERN:   rd_val = pattern;
         `GPBM_REG_PATMASK:   rd_val = pat_mask;
         `GPBM_REG_DESC_ADDR: rd_val = desc_addr;
         `GPBM_REG_STATUS:    rd_val = {26'h0000000, st_drop, st_pat, st_wake, st_pause,
                                        lo_vld, hi_vld};
         `GPBM_REG_LEVEL:     rd_val = {4'h0, tx_used, 2'h0, rx_used};
         default:             rd_val = 32'h00000000;
      endcase
   end

   // ==========================================================
   // configuration writes in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl               <= `GPBM_CTRL_RESET;
         tx_burst_code      <= `GPBM_BURST_RESET;
         tx_fifo_threshold  <= `GPBM_TX_THR_RESET;
         rx_burst_code      <= `GPBM_BURST_RESET;
         rx_fifo_threshold  <= `GPBM_RX_THR_RESET;
         early_tx_threshold <= `GPBM_ETT_RESET;
         mac_addr           <= 48'h000000000000;
         hash_tbl           <= 64'h0000000000000000;
         type_match         <= 16'h0000;
         pattern            <= 32'h00000000;
         pat_mask           <= 32'h00000000;
         desc_addr          <= 32'h00000000;
      end else if (wr_go) begin
         case (ap_addr)
            `GPBM_REG_CTRL:      ctrl <= hwdata[7:0];
            `GPBM_REG_TXCFG: begin
               tx_burst_code     <= hwdata[2:0];
               tx_fifo_threshold <= hwdata[15:4];
            end
            `GPBM_REG_RXCFG: begin
               rx_burst_code     <= hwdata[2:0];
               rx_fifo_threshold <= hwdata[17:4];
            end
            `GPBM_REG_ETT:       early_tx_threshold <= hwdata[11:0];
            `GPBM_REG_MAC_LO:    mac_addr[31:0]     <= hwdata;
            `GPBM_REG_MAC_HI:    mac_addr[47:32]    <= hwdata[15:0];
            `GPBM_REG_HASH_LO:   hash_tbl[31:0]     <= hwdata;
            `GPBM_REG_HASH_HI:   hash_tbl[63:32]    <= hwdata;
            `GPBM_REG_TYPE:      type_match         <= hwdata[15:0];
            `GPBM_REG_PATTERN:   pattern            <= hwdata;
            `GPBM_REG_PATMASK:   pat_mask           <= hwdata;
            `GPBM_REG_DESC_ADDR: desc_addr          <= hwdata;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // sticky recognition flags; a hardware set beats a same-cycle clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_pause <= 1'b0;
         st_wake  <= 1'b0;
         st_pat   <= 1'b0;
         st_drop  <= 1'b0;
      end else begin
         st_pause <= (st_pause & ~(st_wr & hwdata[`GPBM_ST_PAUSE])) | is_pause;
         st_pat   <= (st_pat & ~(st_wr & hwdata[`GPBM_ST_PATTERN])) | pat_hit;
         st_wake  <= (st_wake & ~(st_wr & hwdata[`GPBM_ST_WAKE]))
                   | (pat_hit & ctrl[`GPBM_CTRL_WAKE_EN]);
         st_drop  <= (st_drop & ~(st_wr & hwdata[`GPBM_ST_DROP]))
                   | (rx_mac_valid & rx_full);
      end
   end

   // ==========================================================
   // descriptor slots; a write to a busy slot is ignored
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_vld  <= 1'b0;
         lo_vld  <= 1'b0;
         hi_addr <= 32'h00000000;
         lo_addr <= 32'h00000000;
         hi_len  <= 12'h000;
         lo_len  <= 12'h000;
      end else begin
         if (!tx_act & ctrl[`GPBM_CTRL_TX_EN] & hi_vld)
            hi_vld <= 1'b0; // high slot drained first
         else if (!tx_act & ctrl[`GPBM_CTRL_TX_EN] & lo_vld)
            lo_vld <= 1'b0;
         if (q_wr & hwdata[`GPBM_DESC_HI_BIT] & ~hi_vld & (hwdata[11:0] != 12'h000)) begin
            hi_vld  <= 1'b1; // packet info queued apart from data
            hi_addr <= desc_addr;
            hi_len  <= hwdata[11:0];
         end
         if (q_wr & ~hwdata[`GPBM_DESC_HI_BIT] & ~lo_vld & (hwdata[11:0] != 12'h000)) begin
            lo_vld  <= 1'b1;
            lo_addr <= desc_addr;
            lo_len  <= hwdata[11:0];
         end
      end
   end

   // ==========================================================
   // transmit dma: take a descriptor, burst when space reaches threshold
   // ready is registered and granted only for words the fifo can surely take
   wire [11:0] tx_rem_n  = tx_rem - {11'h000, tx_acc};
   wire [13:0] tx_bl_n   = tx_bl - {13'h0000, tx_acc};
   wire [11:0] tx_free_n = tx_free - {11'h000, tx_acc};
   wire        tx_start  = ~tx_burst & tx_act & ctrl[`GPBM_CTRL_TX_EN]
                         & (tx_free >= tx_fifo_threshold) & (tx_free != 12'h000);
   wire        tx_cont   = tx_burst & (tx_rem_n != 12'h000) & (tx_bl_n != 14'h0000)
                         & (tx_free_n != 12'h000);
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_act       <= 1'b0;
         tx_burst     <= 1'b0;
         tx_rem       <= 12'h000;
         tx_bl        <= 14'h0000;
         tx_dma_req   <= 1'b0;
         tx_dma_ready <= 1'b0;
         tx_dma_addr  <= 32'h00000000;
         tx_dma_hipri <= 1'b0;
      end else begin
         if (!tx_act & ctrl[`GPBM_CTRL_TX_EN] & (hi_vld | lo_vld)) begin
            tx_act       <= 1'b1;
            tx_dma_hipri <= hi_vld;
            tx_dma_addr  <= hi_vld ? hi_addr : lo_addr;
            tx_rem       <= hi_vld ? hi_len : lo_len;
         end else begin
            if (tx_acc)
               tx_dma_addr <= tx_dma_addr + 32'h00000004;
            tx_rem <= tx_rem_n;
            if (tx_acc & (tx_rem_n == 12'h000))
               tx_act <= 1'b0;
         end
         if (tx_start) begin
            tx_burst <= 1'b1;
            tx_bl    <= burst_words(tx_burst_code);
         end else begin
            tx_burst <= tx_cont;
            tx_bl    <= tx_bl_n;
         end
         tx_dma_req   <= tx_start | tx_cont;
         tx_dma_ready <= tx_start | tx_cont; // no write into a full fifo
      end
   end

   // ==========================================================
   // transmit fifo, 2048 words plus end-of-frame bit
   always @(posedge hclk) begin
      if (tx_acc)
         tx_mem[tx_wr[10:0]] <= {tx_last_in, tx_dma_data};
   end

   // pointers, whole-frame count and frame start decision
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_wr      <= 12'h000;
         tx_rd      <= 12'h000;
         tx_frames  <= 12'h000;
         tx_sending <= 1'b0;
      end else begin
         if (tx_acc)
            tx_wr <= tx_wr + 12'h001;
         if (tx_pop)
            tx_rd <= tx_rd + 12'h001;
         // several whole frames may wait, so frames leave back to back
         tx_frames <= tx_frames + {11'h000, tx_last_in} - {11'h000, tx_pop_last};
         if (tx_pop_last)
            tx_sending <= 1'b0;
         else if (!tx_sending & ctrl[`GPBM_CTRL_TX_EN]
                  & ((tx_used >= early_tx_threshold)
                     | (tx_frames != 12'h000)))
            tx_sending <= 1'b1;
      end
   end

   // toward the transmit mac, a stall there loses no word
   gpbm_skid #(.W(33)) u_tx_skid (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_data   (tx_head),
      .in_valid  (tx_pop),
      .in_ready  (tx_skid_rdy),
      .out_data  ({tx_mac_last, tx_mac_data}),
      .out_valid (tx_mac_valid),
      .out_ready (tx_mac_ready)
   );

   // ==========================================================
   // receive write side: frames land past the commit point and are
   // kept or rewound at their last word, so rejected frames cost nothing
   always @(posedge hclk) begin
      if (rx_mac_valid & ~rx_drop_now)
         rx_mem[rx_wr[12:0]] <= {rx_mac_last, rx_mac_data};
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_wr       <= 14'h0000;
         rx_cm       <= 14'h0000;
         rx_idx      <= 2'h0;
         rx_w0       <= 32'h00000000;
         rx_pass     <= 1'b0;
         st_drop_frm <= 1'b0;
      end else if (rx_mac_valid) begin
         if (rx_mac_last) begin
            rx_idx      <= 2'h0;
            st_drop_frm <= 1'b0;
            if (rx_commit) begin
               rx_wr <= rx_wr + 14'h0001;
               rx_cm <= rx_wr + 14'h0001;
            end else
               rx_wr <= rx_cm; // rejected, runt or overflowed frame
         end else begin
            if (rx_idx != 2'h3)
               rx_idx <= rx_idx + 2'h1;
            if (rx_idx == 2'h0)
               rx_w0 <= rx_mac_data;
            if (rx_idx == 2'h1)
               rx_pass <= addr_ok & type_ok;
            if (rx_drop_now)
               st_drop_frm <= 1'b1; // full fifo: drop rest of frame
            else
               rx_wr <= rx_wr + 14'h0001;
         end
      end
   end

   // ==========================================================
   // receive dma: request at threshold, burst until empty, frame end or limit
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_rd      <= 14'h0000;
         rx_frames  <= 14'h0000;
         rx_busy    <= 1'b0;
         rx_bl      <= 14'h0000;
         rx_dma_req <= 1'b0;
      end else begin
         if (rx_pop)
            rx_rd <= rx_rd + 14'h0001;
         rx_frames <= rx_frames + {13'h0000, rx_commit} - {13'h0000, rx_pop_last};
         if (!rx_busy) begin
            // a committed frame end also starts a burst, else a short tail would stick
            if ((rx_avail != 14'h0000)
                & ((rx_avail >= rx_fifo_threshold) | (rx_frames != 14'h0000))) begin
               rx_busy    <= 1'b1;
               rx_dma_req <= 1'b1;
               rx_bl      <= burst_words(rx_burst_code);
            end
         end else if (rx_pop) begin
            rx_bl <= rx_bl - 14'h0001;
            if (rx_head[32] | (rx_bl == 14'h0001) | (rx_avail == 14'h0001)) begin
               rx_busy    <= 1'b0;
               rx_dma_req <= 1'b0;
            end
         end else if (rx_avail == 14'h0000) begin
            rx_busy    <= 1'b0; // less than one word left
            rx_dma_req <= 1'b0;
         end
      end
   end

   // toward receive dma, independent of the transmit path
   gpbm_skid #(.W(33)) u_rx_skid (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_data   (rx_head),
      .in_valid  (rx_pop),
      .in_ready  (rx_skid_rdy),
      .out_data  ({rx_dma_last, rx_dma_data}),
      .out_valid (rx_dma_valid),
      .out_ready (rx_dma_ready)
   );
endmodule // gpbm_top

// ---- tb/gpbm_checker.sv ----
// port assertions for the packet buffer manager
`timescale 1ns/1ps
module gpbm_checker (
   // clock, reset and bus answer
   input wire logic        hclk, hresetn, hresp, hreadyout,
   // transmit side
   input wire logic        tx_dma_req, tx_dma_ready, tx_dma_valid, tx_mac_valid, tx_mac_ready,
   input wire logic [31:0] tx_dma_addr, tx_mac_data,
   // receive side
   input wire logic        rx_dma_req, rx_dma_valid, rx_dma_ready, rx_dma_last,
   input wire logic [31:0] rx_dma_data
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ==========
   // accepted words on each memory side
   sequence tx_beat; tx_dma_valid && tx_dma_ready; endsequence
   sequence rx_end; rx_dma_valid && rx_dma_ready && rx_dma_last; endsequence
   AST_AHB_OKAY: assert property (hreadyout && !hresp) else $error("bus answer not okay");
   AST_TX_READY: assert property (tx_dma_ready |-> tx_dma_req)
      else $error("fetch ready outside burst");
   AST_TX_ROSE: assert property ($rose(tx_dma_req) |-> tx_dma_ready)
      else $error("burst opened without ready");
   AST_TX_HOLD: assert property (tx_dma_req && !tx_dma_valid |=> tx_dma_req)
      else $error("burst closed with no word moved");
   AST_TX_ADDR: assert property (tx_beat |=> tx_dma_addr == $past(tx_dma_addr) + 32'h4)
      else $error("fetch address did not step");
   AST_TXMAC_HOLD: assert property (tx_mac_valid && !tx_mac_ready
      |=> tx_mac_valid && $stable(tx_mac_data)) else $error("mac word lost in stall");
   AST_RXDMA_HOLD: assert property (rx_dma_valid && !rx_dma_ready
      |=> rx_dma_valid && $stable(rx_dma_data)) else $error("receive word lost in stall");
   AST_RX_END: assert property (rx_end |-> ##[1:2] !rx_dma_req)
      else $error("receive burst ran past frame end");
endmodule // gpbm_checker

bind gpbm_top gpbm_checker u_gpbm_checker (.*);

// ---- tb/gpbm_mem_model.sv ----
// system memory model: serves transmit fetches, drains receive words
`timescale 1ns/1ps
module gpbm_mem_model (
   // clock, reset and pace
   input  wire logic        hclk, hresetn, slow,
   // transmit fetch
   input  wire logic        tx_dma_ready,
   input  wire logic [31:0] tx_dma_addr,
   output logic      [31:0] tx_dma_data,
   output logic             tx_dma_valid,
   // receive drain
   output logic             rx_dma_ready
);
   // ==========
   // each word equals its byte address; slow pace skips every other cycle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_dma_valid <= 1'b0;
         tx_dma_data  <= 32'h0;
         rx_dma_ready <= 1'b0;
      end else begin
         rx_dma_ready <= slow ? ~rx_dma_ready : 1'b1;
         tx_dma_valid <= tx_dma_ready && !(slow && tx_dma_valid);
         // idle lines toggle so a stale word never looks valid
         tx_dma_data  <= !tx_dma_ready ? ~tx_dma_data
                       : tx_dma_addr + ((tx_dma_valid && tx_dma_ready) ? 32'h4 : 32'h0);
      end
   end
endmodule // gpbm_mem_model

// ---- tb/tb.sv ----
// register-level testbench of the packet buffer manager
`timescale 1ns/1ps
module tb;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, tx_mac_ready = 0, slow = 1;
   logic        rx_mac_valid = 0, rx_mac_last = 0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rx_mac_data = 32'h0;
   wire         hready, hreadyout, hresp, tx_dma_req, tx_dma_hipri, tx_dma_ready, tx_dma_valid;
   wire         tx_mac_last, tx_mac_valid, rx_dma_req, rx_dma_last, rx_dma_valid, rx_dma_ready;
   wire  [31:0] hrdata, tx_dma_addr, tx_dma_data, tx_mac_data, rx_dma_data;
   logic [32:0] txq[$], rxq[$];
   int          mismatches = 0, cmp_count = 0, i;
   assign hready = hreadyout;
   gpbm_top u_gpbm_top (.*);
   gpbm_mem_model u_gpbm_mem_model (.*);
   initial forever #4 hclk = ~hclk;
   // collect words out of both fifos; the mac stalls every other cycle
   always @(posedge hclk) begin
      if (tx_mac_valid && tx_mac_ready) txq.push_back({tx_mac_last, tx_mac_data});
      if (rx_dma_valid && rx_dma_ready) rxq.push_back({rx_dma_last, rx_dma_data});
      tx_mac_ready <= ~tx_mac_ready;
   end
   task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic stop_test;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ==========
   // ahb-lite single word transfer, bounded wait on hready
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
      if (n >= 100) begin mismatches++; stop_test; end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      haddr <= a; hwrite <= w; htrans <= 2'h2; hsel <= 1'b1;
      wait_rdy;
      htrans <= 2'h0; hwdata <= d;
      wait_rdy;
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [31:0] a, e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk("register", {1'b0, e}, {1'b0, r});
   endtask
   // ==========
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rd(32'h04, 32'h1002);
      rd(32'h08, 32'h402);
      rd(32'h0C, 32'h80);
      rd(32'h3C, 32'h0);
      // queue low then high while transmit is off, so both wait
      wr(32'h2C, 32'h1000);
      wr(32'h30, 32'h3);
      wr(32'h2C, 32'h2000);
      wr(32'h30, 32'h80000002);
      rd(32'h34, 32'h3);
      wr(32'h00, 32'h43);
      for (i = 0; i < 50 && tx_dma_req !== 1'b1; i++) @(posedge hclk);
      if (i == 50) begin mismatches++; stop_test; end
      chk("high first", 33'h1, {32'h0, tx_dma_hipri});
      // three-word frame from the receive mac, no back-pressure there
      for (i = 0; i < 3; i++) begin
         rx_mac_valid <= 1'b1; rx_mac_last <= (i == 2); rx_mac_data <= 32'hFFFFFF00 + i;
         @(posedge hclk);
      end
      rx_mac_valid <= 1'b0; rx_mac_last <= 1'b0;
      for (i = 0; i < 2000 && (txq.size() < 5 || rxq.size() < 3); i++) @(posedge hclk);
      if (i == 2000) begin mismatches++; stop_test; end
      for (int k = 0; k < 5; k++)
         chk("tx word", k < 2 ? {k == 1, 32'h2000 + 4 * k}
                              : {k == 4, 32'h1000 + 4 * (k - 2)}, txq[k]);
      for (int k = 0; k < 3; k++)
         chk("rx word", {k == 2, 32'hFFFFFF00 + k}, rxq[k]);
      rd(32'h38, 32'h0);
      stop_test;
   end
endmodule // tb
